/* File: hw/tec_alert.sv */
// Alert source selection, mode latch, enable and pin polarity
module tec_alert (
  input  wire logic     clock, // System clock
  input  wire logic     rst_n, // Async reset, active low
  tec_link_if.alert_side link  // Trip bits in, alert state out
);
  import tec_pkg::*;

  logic qual;
  logic qual_prev_reg;
  logic latch_reg;
  logic event_now;
  logic active;

  assign qual = link.crit_only ? link.trip[2] : (|link.trip);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      qual_prev_reg <= 1'b0;
    end else begin
      qual_prev_reg <= qual;
    end
  end

  // A new trip wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= 1'b0;
    end else if (!link.mode_int) begin
      latch_reg <= 1'b0;
    end else if (qual && !qual_prev_reg) begin
      latch_reg <= 1'b1;
    end else if (link.clear) begin
      latch_reg <= 1'b0;
    end
  end

  assign event_now = link.mode_int ? latch_reg : qual;
  assign active    = event_now && link.out_enable;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.alert_flag    <= 1'b0;
      link.alert_pin_low <= 1'b0;
    end else begin
      link.alert_flag    <= active;
      link.alert_pin_low <= link.polarity_high ? !active : active;
    end
  end
endmodule : tec_alert

/* File: hw/tec_core.sv */
// Configuration, boundary and trip status logic driving the alert pin
module tec_core (
  input  wire logic                            clock,       // 250 MHz clock
  input  wire logic                            rst_n,       // Power-on reset, active low
  input  wire logic [tec_pkg::REG_AW-1:0]      reg_addr,    // Register pointer
  input  wire logic                            reg_wr_en,   // Write strobe
  input  wire logic [tec_pkg::DATA_W-1:0]      reg_wr_data, // Write data
  input  wire logic                            reg_rd_en,   // Read strobe
  output logic      [tec_pkg::DATA_W-1:0]      reg_rd_data, // Read data, registered
  input  wire logic                            temp_valid,  // New conversion pulse
  input  wire logic [tec_pkg::TEMP_W-1:0]      temp_value,  // Signed temperature
  output logic                                 alert_o,     // Alert pin output level
  output logic                                 alert_oe     // Alert pin drive enable
);
  import tec_pkg::*;

  tec_link_if link ();

  logic        crit_lock_reg;
  logic        window_lock_reg;
  logic        alert_output_enable_reg;
  logic        critical_only_select_reg;
  logic        alert_polarity_reg;
  logic        alert_mode_select_reg;
  tec_hyst_t   hyst_reg;
  logic [15:0] upper_reg;
  logic [15:0] lower_reg;
  logic [15:0] crit_reg;
  logic [12:0] temp_reg;
  logic        any_lock;
  logic        cfg_wr;
  logic        clear_pulse_reg;
  logic [15:0] cfg_view;
  logic [15:0] rd_next;

  assign any_lock = crit_lock_reg || window_lock_reg;
  assign cfg_wr   = reg_wr_en && (reg_addr == CFG_ADDR);

  // Lock bits: set by one write, cleared only by reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crit_lock_reg   <= 1'b0;
      window_lock_reg <= 1'b0;
    end else if (cfg_wr) begin
      if (reg_wr_data[CRIT_LOCK_BIT]) begin
        crit_lock_reg <= 1'b1;
      end
      if (reg_wr_data[WIN_LOCK_BIT]) begin
        window_lock_reg <= 1'b1;
      end
    end
  end

  // Lockable control fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alert_output_enable_reg  <= 1'b0;
      critical_only_select_reg <= 1'b0;
      alert_polarity_reg       <= 1'b0;
      alert_mode_select_reg    <= 1'b0;
      hyst_reg                 <= TEC_HYST_NONE;
    end else if (cfg_wr && !any_lock) begin
      alert_output_enable_reg  <= reg_wr_data[ENABLE_BIT];
      critical_only_select_reg <= reg_wr_data[CRIT_ONLY_BIT];
      alert_polarity_reg       <= reg_wr_data[POLARITY_BIT];
      alert_mode_select_reg    <= reg_wr_data[MODE_BIT];
      hyst_reg                 <= tec_hyst_t'(reg_wr_data[HYST_MSB:HYST_LSB]);
    end
  end

  // Clear strobe, a one-cycle pulse; ignored outside interrupt mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clear_pulse_reg <= 1'b0;
    end else begin
      clear_pulse_reg <= cfg_wr && reg_wr_data[CLEAR_BIT] && alert_mode_select_reg;
    end
  end

  // Boundary registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upper_reg <= BOUND_RESET;
      lower_reg <= BOUND_RESET;
    end else if (reg_wr_en && !window_lock_reg) begin
      if (reg_addr == UPPER_ADDR) begin
        upper_reg <= reg_wr_data & BOUND_MASK;
      end
      if (reg_addr == LOWER_ADDR) begin
        lower_reg <= reg_wr_data & BOUND_MASK;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      crit_reg <= BOUND_RESET;
    end else if (reg_wr_en && !crit_lock_reg && reg_addr == CRIT_ADDR) begin
      crit_reg <= reg_wr_data & BOUND_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      temp_reg <= '0;
    end else if (temp_valid) begin
      temp_reg <= temp_value;
    end
  end

  // Shared signals toward the helpers
  assign link.sample        = temp_valid;
  assign link.temp          = {{3{temp_value[TEMP_W-1]}}, temp_value};
  assign link.mode_int      = alert_mode_select_reg;
  assign link.crit_only     = critical_only_select_reg;
  assign link.out_enable    = alert_output_enable_reg;
  assign link.polarity_high = alert_polarity_reg;
  assign link.clear         = clear_pulse_reg;

  always_comb begin
    unique case (hyst_reg)
      TEC_HYST_NONE: link.hyst = HYST_0_0;
      TEC_HYST_1P5:  link.hyst = HYST_1_5;
      TEC_HYST_3P0:  link.hyst = HYST_3_0;
      TEC_HYST_6P0:  link.hyst = HYST_6_0;
    endcase
  end

  // Status bits 13, 14, 15 of the temperature reading
  tec_trip #(.ABOVE(1'b0), .STRICT(1'b0)) u_below (
    .clock     (clock),
    .rst_n     (rst_n),
    .link      (link),
    .threshold ({{3{lower_reg[12]}}, lower_reg[12:0]}),
    .status    (link.trip[0])
  );

  tec_trip #(.ABOVE(1'b1), .STRICT(1'b1)) u_above (
    .clock     (clock),
    .rst_n     (rst_n),
    .link      (link),
    .threshold ({{3{upper_reg[12]}}, upper_reg[12:0]}),
    .status    (link.trip[1])
  );

  tec_trip #(.ABOVE(1'b1), .STRICT(1'b0)) u_crit (
    .clock     (clock),
    .rst_n     (rst_n),
    .link      (link),
    .threshold ({{3{crit_reg[12]}}, crit_reg[12:0]}),
    .status    (link.trip[2])
  );

  tec_alert u_alert (
    .clock (clock),
    .rst_n (rst_n),
    .link  (link)
  );

  // Open-drain pin: drive low only
  assign alert_o  = 1'b0;
  assign alert_oe = link.alert_pin_low;

  always_comb begin
    cfg_view                    = '0;
    cfg_view[HYST_MSB:HYST_LSB] = hyst_reg;
    cfg_view[CRIT_LOCK_BIT]     = crit_lock_reg;
    cfg_view[WIN_LOCK_BIT]      = window_lock_reg;
    cfg_view[CLEAR_BIT]         = 1'b0;
    cfg_view[FLAG_BIT]          = link.alert_flag;
    cfg_view[ENABLE_BIT]        = alert_output_enable_reg;
    cfg_view[CRIT_ONLY_BIT]     = critical_only_select_reg;
    cfg_view[POLARITY_BIT]      = alert_polarity_reg;
    cfg_view[MODE_BIT]          = alert_mode_select_reg;
  end

  always_comb begin
    unique case (reg_addr)
      CFG_ADDR:   rd_next = cfg_view;
      UPPER_ADDR: rd_next = upper_reg;
      LOWER_ADDR: rd_next = lower_reg;
      CRIT_ADDR:  rd_next = crit_reg;
      TEMP_ADDR:  rd_next = {link.trip[2], link.trip[1], link.trip[0], temp_reg};
      default:    rd_next = '0;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= '0;
    end else if (reg_rd_en) begin
      reg_rd_data <= rd_next;
    end
  end
endmodule : tec_core

/* File: hw/tec_link_if.sv */
// Signals shared between the control core and its trip and alert helpers
interface tec_link_if;
  import tec_pkg::*;
  logic               sample;
  logic signed [15:0] temp;
  logic signed [15:0] hyst;
  logic [2:0]         trip;
  logic               mode_int;
  logic               crit_only;
  logic               out_enable;
  logic               polarity_high;
  logic               clear;
  logic               alert_flag;
  logic               alert_pin_low;

  modport core  (output sample, temp, hyst, mode_int, crit_only, out_enable,
                 polarity_high, clear, input trip, alert_flag, alert_pin_low);
  modport trip_side  (input sample, temp, hyst);
  modport alert_side (input trip, mode_int, crit_only, out_enable, polarity_high, clear,
                      output alert_flag, alert_pin_low);
endinterface : tec_link_if

/* File: hw/tec_pkg.sv */
// Shared constants for the thermal event output control block
package tec_pkg;
  localparam int unsigned      REG_AW           = 8;
  localparam int unsigned      DATA_W           = 16;
  localparam int unsigned      TEMP_W           = 13;
  // Register pointers
  localparam logic [7:0]       CFG_ADDR         = 8'h01;
  localparam logic [7:0]       UPPER_ADDR       = 8'h02;
  localparam logic [7:0]       LOWER_ADDR       = 8'h03;
  localparam logic [7:0]       CRIT_ADDR        = 8'h04;
  localparam logic [7:0]       TEMP_ADDR        = 8'h05;
  // Configuration field positions
  localparam int unsigned      CRIT_LOCK_BIT    = 7;
  localparam int unsigned      WIN_LOCK_BIT     = 6;
  localparam int unsigned      CLEAR_BIT        = 5;
  localparam int unsigned      FLAG_BIT         = 4;
  localparam int unsigned      ENABLE_BIT       = 3;
  localparam int unsigned      CRIT_ONLY_BIT    = 2;
  localparam int unsigned      POLARITY_BIT     = 1;
  localparam int unsigned      MODE_BIT         = 0;
  localparam int unsigned      HYST_LSB         = 9;
  localparam int unsigned      HYST_MSB         = 10;
  // Temperature status bit positions
  localparam int unsigned      BELOW_BIT        = 13;
  localparam int unsigned      ABOVE_BIT        = 14;
  localparam int unsigned      CRIT_BIT         = 15;
  // Writable bits of a boundary register (sign and value, rest reads zero)
  localparam logic [15:0]      BOUND_MASK       = 16'h1FFC;
  localparam logic [15:0]      BOUND_RESET      = 16'h0000;
  localparam logic [1:0]       HYST_RESET       = 2'h0;
  // Hysteresis in steps of 0.0625 degrees
  localparam logic [15:0]      HYST_0_0         = 16'h0000;
  localparam logic [15:0]      HYST_1_5         = 16'h0018;
  localparam logic [15:0]      HYST_3_0         = 16'h0030;
  localparam logic [15:0]      HYST_6_0         = 16'h0060;

  typedef enum logic [1:0] {
    TEC_HYST_NONE = 2'b00,
    TEC_HYST_1P5  = 2'b01,
    TEC_HYST_3P0  = 2'b10,
    TEC_HYST_6P0  = 2'b11
  } tec_hyst_t;
endpackage : tec_pkg

/* File: hw/tec_trip.sv */
// One hysteresis-aware trip status bit
module tec_trip #(
  parameter bit ABOVE  = 1'b1,   // Sets on rising temperature
  parameter bit STRICT = 1'b0    // Set needs temp strictly above threshold
) (
  input  wire logic               clock,     // System clock
  input  wire logic               rst_n,     // Async reset, active low
  tec_link_if.trip_side           link,      // Shared sample and hysteresis
  input  wire logic signed [15:0] threshold, // Trip point, sign extended
  output logic                    status     // Trip status bit
);
  import tec_pkg::*;

  logic signed [15:0] low_point;
  logic signed [15:0] prev_temp_reg;
  logic               set_cond;
  logic               clr_cond;
  logic               rising;
  logic               falling;

  assign low_point = threshold - link.hyst;
  assign rising    = link.temp > prev_temp_reg;
  assign falling   = link.temp < prev_temp_reg;

  always_comb begin
    if (ABOVE) begin
      set_cond = STRICT ? (link.temp > threshold) : (link.temp >= threshold);
      clr_cond = link.temp <= low_point;
    end else begin
      set_cond = link.temp <= low_point;
      clr_cond = link.temp >= threshold;
    end
  end

  // Last sample gives the slope where a zero-width band makes both conditions true
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_temp_reg <= '0;
    end else if (link.sample) begin
      prev_temp_reg <= link.temp;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= 1'b0;
    end else if (link.sample) begin
      if (set_cond && clr_cond) begin
        if (ABOVE ? rising : falling) begin
          status <= 1'b1;
        end else if (ABOVE ? falling : rising) begin
          status <= 1'b0;
        end
      end else if (set_cond) begin
        status <= 1'b1;
      end else if (clr_cond) begin
        status <= 1'b0;
      end
    end
  end
endmodule : tec_trip

/* File: testbench/tec_core_props.sv */
// Port checker for the thermal event control core
module tec_core_props (
  input wire logic        clock,       // Clock
  input wire logic        rst_n,       // Reset, active low
  input wire logic [7:0]  reg_addr,    // Register pointer
  input wire logic        reg_wr_en,   // Write strobe
  input wire logic [15:0] reg_wr_data, // Write data
  input wire logic        reg_rd_en,   // Read strobe
  input wire logic [15:0] reg_rd_data, // Read data
  input wire logic        temp_valid,  // Conversion pulse
  input wire logic [12:0] temp_value,  // Temperature
  input wire logic        alert_o,     // Pin level
  input wire logic        alert_oe     // Pin enable
);
  import tec_pkg::*;
  logic [5:0] sh_reg;
  logic       ck_reg;
  logic       wk_reg;
  wire        cfg_wr = reg_wr_en && reg_addr == CFG_ADDR;
  wire        cfg_rd = reg_rd_en && reg_addr == CFG_ADDR;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Expected lock bits and lockable fields
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sh_reg <= 6'h00;
      ck_reg <= 1'b0;
      wk_reg <= 1'b0;
    end else if (cfg_wr) begin
      ck_reg <= ck_reg | reg_wr_data[7];
      wk_reg <= wk_reg | reg_wr_data[6];
      if (!(ck_reg || wk_reg)) begin
        sh_reg <= {reg_wr_data[10:9], reg_wr_data[3:0]};
      end
    end
  end
  sequence clr_sent;
    (!temp_valid)[*4] ##0 (cfg_wr && reg_wr_data[5] && reg_wr_data[3:0] == sh_reg[3:0]
      && sh_reg[1:0] == 2'b01 && !(ck_reg || wk_reg));
  endsequence
  sequence idle_cfg;
    (sh_reg[3] == 1'b0 && sh_reg[1] == 1'b0)[*4];
  endsequence
  chk_pin_open_drain: assert property (alert_o == 1'b0)
    else $error("alert pin driven high");
  chk_crit_lock_read: assert property (cfg_rd |=> reg_rd_data[7] == $past(ck_reg))
    else $error("critical lock readback wrong");
  chk_win_lock_read: assert property (cfg_rd |=> reg_rd_data[6] == $past(wk_reg))
    else $error("window lock readback wrong");
  chk_clear_reads_zero: assert property (cfg_rd |=> !reg_rd_data[CLEAR_BIT])
    else $error("clear bit read as one");
  chk_flag_needs_enable: assert property ((!sh_reg[3])[*3] ##0 cfg_rd |=> !reg_rd_data[4])
    else $error("flag set with output disabled");
  chk_oe_idle_off: assert property (idle_cfg |-> !alert_oe)
    else $error("pin driven while disabled");
  chk_cfg_locked_bits: assert property (cfg_rd |=>
    {reg_rd_data[10:9], reg_rd_data[3:0]} == $past(sh_reg))
    else $error("lockable config bits wrong");
  chk_clear_drops: assert property (clr_sent ##1 (!temp_valid)[*2] |=> !alert_oe)
    else $error("alert not cleared by strobe");
endmodule : tec_core_props
bind tec_core tec_core_props u_tec_core_props (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .temp_valid(temp_valid),
  .temp_value(temp_value), .alert_o(alert_o), .alert_oe(alert_oe));

/* File: testbench/tec_host_model.sv */
// Host side of the alert pin: open-drain wire with a pull-up
module tec_host_model (
  input  wire logic alert_o,   // Drive level from the device
  input  wire logic alert_oe,  // Drive enable from the device
  output logic      pin_level  // Wire level the host sees
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pin floats to the pull-up level
  assign pin_level = alert_oe ? alert_o : 1'b1;
endmodule : tec_host_model

/* File: testbench/thermal_event_output_control_tb.sv */
// Register-level testbench for the thermal event control core
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module thermal_event_output_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tec_pkg::*;
  logic        clock, rst_n, reg_wr_en, reg_rd_en, temp_valid, alert_o, alert_oe, pin_level;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wr_data, reg_rd_data, rd_val;
  logic [12:0] temp_value, h;
  logic [12:0] tv [6];
  logic [2:0]  ev [6] = '{3'b010, 3'b010, 3'b000, 3'b001, 3'b001, 3'b000};
  logic [15:0] hv [4] = '{HYST_0_0, HYST_1_5, HYST_3_0, HYST_6_0};
  int          mismatches, cmp_count, cycles;
  tec_core u_tec_core (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .temp_valid(temp_valid), .temp_value(temp_value),
    .alert_o(alert_o), .alert_oe(alert_oe));
  tec_host_model u_tec_host_model (.alert_o(alert_o), .alert_oe(alert_oe),
    .pin_level(pin_level));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clock);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    #1 rd_val = reg_rd_data;
  endtask : rd
  task automatic tin(input logic [12:0] v);
    @(posedge clock);
    temp_value <= v;
    temp_valid <= 1'b1;
    @(posedge clock);
    temp_valid <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask : tin
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // Run limit well above the expected length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    {rst_n, reg_wr_en, reg_rd_en, temp_valid} = 4'h0;
    reg_addr = 8'h00;
    reg_wr_data = 16'h0000;
    temp_value = 13'h0000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    wr(8'h00, 16'h00FF);
    rd(8'h00); `CHK(rd_val, 16'h0000)
    rd(CFG_ADDR); `CHK(rd_val, 16'h0000)
    $display("test reset done");
    wr(CFG_ADDR, 16'h0238);
    rd(CFG_ADDR); `CHK(rd_val, 16'h0208)
    wr(CRIT_ADDR, 16'h0100);
    wr(UPPER_ADDR, 16'h0200);
    wr(LOWER_ADDR, 16'h0080);
    tin(13'h0100); `CHK(pin_level, 1'b0)
    rd(TEMP_ADDR); `CHK(rd_val, 16'h8100)
    rd(CFG_ADDR); `CHK(rd_val, 16'h0218)
    tin(13'h00F0);
    rd(TEMP_ADDR); `CHK(rd_val, 16'h80F0)
    tin(13'h00E8); `CHK(pin_level, 1'b1)
    wr(CRIT_ADDR, 16'h0400);
    tin(13'h0210); `CHK(pin_level, 1'b0)
    wr(CFG_ADDR, 16'h020C);
    rd(CFG_ADDR); `CHK(rd_val, 16'h020C)
    `CHK(pin_level, 1'b1)
    $display("test comparator done");
    for (int i = 0; i < 4; i++) begin
      h = hv[i][12:0];
      tv = '{13'h0210, 13'h0208 - h, 13'h0200 - h, 13'h0078 - h, 13'h0078, 13'h0080};
      wr(CFG_ADDR, {5'h00, i[1:0], 9'h008});
      for (int j = 0; j < 6; j++) begin
        tin(tv[j]);
        rd(TEMP_ADDR); `CHK(rd_val, {ev[j], tv[j]})
      end
    end
    $display("test hysteresis done");
    wr(CFG_ADDR, 16'h0009);
    tin(13'h0210); `CHK(pin_level, 1'b0)
    tin(13'h0100); `CHK(pin_level, 1'b0)
    wr(CFG_ADDR, 16'h0029);
    settle(); `CHK(pin_level, 1'b1)
    rd(CFG_ADDR); `CHK(rd_val, 16'h0009)
    wr(CFG_ADDR, 16'h0008);
    tin(13'h0210);
    wr(CFG_ADDR, 16'h0028);
    settle(); `CHK(pin_level, 1'b0)
    tin(13'h0100); `CHK(pin_level, 1'b1)
    wr(CFG_ADDR, 16'h000A);
    settle(); `CHK(pin_level, 1'b0)
    tin(13'h0210); `CHK(pin_level, 1'b1)
    tin(13'h0100);
    $display("test alert modes done");
    // Locks set here although hosts should leave them clear
    wr(CFG_ADDR, 16'h0009);
    wr(CFG_ADDR, 16'h0089);
    wr(CRIT_ADDR, 16'h0300);
    rd(CRIT_ADDR); `CHK(rd_val, 16'h0400)
    wr(CFG_ADDR, 16'h0006);
    rd(CFG_ADDR); `CHK(rd_val, 16'h0089)
    wr(UPPER_ADDR, 16'h0300);
    rd(UPPER_ADDR); `CHK(rd_val, 16'h0300)
    wr(CFG_ADDR, 16'h00C9);
    wr(UPPER_ADDR, 16'h0100);
    wr(LOWER_ADDR, 16'h0010);
    rd(UPPER_ADDR); `CHK(rd_val, 16'h0300)
    rd(LOWER_ADDR); `CHK(rd_val, 16'h0080)
    rd(CFG_ADDR); `CHK(rd_val, 16'h00C9)
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(CFG_ADDR); `CHK(rd_val, 16'h0000)
    rd(CRIT_ADDR); `CHK(rd_val, 16'h0000)
    $display("test locks done");
    test_done();
  end
endmodule : thermal_event_output_control_tb
